// [hw/dac_pkg.sv]
// shared constants for the serial converter front end
// assumes a single 250 MHz system clock and an AHB-Lite register bus
package dac_pkg;

  // ---------------------------------------------------------------
  // serial word layout
  // ---------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int COUNT_BITS = 5;
  localparam logic [COUNT_BITS-1:0] WORD_EDGES = 5'h10;
  localparam logic [COUNT_BITS-1:0] LAST_EDGE_COUNT = 5'h0F;
  localparam logic [COUNT_BITS-1:0] COUNT_RESET = 5'h00;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [DATA_BITS-1:0] LATCH_RESET = 12'h000;
  localparam logic [DATA_BITS-1:0] CODE_RESET = 12'h000;
  localparam logic [DATA_BITS-1:0] MSB_FLIP = 12'h800;

  // ---------------------------------------------------------------
  // synchronised pin vector positions
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam int PIN_SCLK = 0;
  localparam int PIN_FRAME = 1;
  localparam int PIN_DATA = 2;
  localparam int PIN_LOAD = 3;
  localparam int PIN_CLEAR = 4;
  localparam int PIN_CHAIN = 5;
  // idle level of each pin: clocks, frame, strobes high
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 6'h1B;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_BITS = 8;
  localparam logic [ADDR_BITS-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_BITS-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_BITS-1:0] LATCH_ADDR = 8'h08;
  localparam logic [ADDR_BITS-1:0] CODE_ADDR = 8'h0C;
  localparam logic [ADDR_BITS-1:0] SHIFT_ADDR = 8'h10;
  localparam int CTRL_FORMAT_BIT = 0;
  localparam int CTRL_BIPOLAR_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_AUTO_BIT = 0;
  localparam int STAT_FRAME_BIT = 1;
  localparam int STAT_CLEAR_BIT = 2;
  localparam int STAT_CHAIN_BIT = 3;
  localparam int STAT_COUNT_LSB = 4;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // core code: straight binary fraction of the output span
  function automatic logic [DATA_BITS-1:0] core_code(
    input logic [DATA_BITS-1:0] latch,
    input logic format_select,
    input logic bipolar
  );
    if (bipolar && format_select)
    begin
      core_code = latch ^ MSB_FLIP;
    end
    else
    begin
      core_code = latch;
    end
  endfunction

endpackage

// [hw/pin_if.sv]
// synchronised pin levels and edge pulses between the pin stage and the core
// assumes both ends run on the one system clock
`timescale 1ns/10ps
interface pin_if;
  import dac_pkg::*;
  logic [PIN_COUNT-1:0] level;
  logic sclk_fall;
  logic frame_fall;
  logic load_fall;

  modport sync_end (output level, output sclk_fall, output frame_fall, output load_fall);
  modport core_end (input level, input sclk_fall, input frame_fall, input load_fall);
endinterface

// [hw/pin_sync.sv]
// two-flop synchronisers for all six pins plus falling edge detection on clock, frame and load
// assumes raw pins are asynchronous to clock
`timescale 1ns/10ps
module pin_sync
  import dac_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [dac_pkg::PIN_COUNT-1:0] pins_raw,
  pin_if.sync_end pins
);

  logic [PIN_COUNT-1:0] meta_q;
  logic [PIN_COUNT-1:0] meta_d;
  logic [PIN_COUNT-1:0] sync_q;
  logic [PIN_COUNT-1:0] sync_d;
  logic [PIN_COUNT-1:0] prev_q;
  logic [PIN_COUNT-1:0] prev_d;

  // ---------------------------------------------------------------
  // synchroniser chain
  // ---------------------------------------------------------------
  // first stage feeds only the second stage
  always_comb
  begin
    meta_d = pins_raw;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // ---------------------------------------------------------------
  // edge pulses
  // ---------------------------------------------------------------
  assign pins.level = sync_q;
  assign pins.sclk_fall = prev_q[PIN_SCLK] & ~sync_q[PIN_SCLK];
  assign pins.frame_fall = prev_q[PIN_FRAME] & ~sync_q[PIN_FRAME];
  assign pins.load_fall = prev_q[PIN_LOAD] & ~sync_q[PIN_LOAD];

endmodule

// [hw/serial_dac_input_logic.sv]
// serial input shift register, converter latch and register slave
// assumes link pins asynchronous to clock, host period well above 16 ns
// Behaviour
// - low clear forces latch to zeros
// - zero code gives zero or most negative
// - unipolar coding is straight binary
// - bipolar with format high is two's complement
// - bipolar format low: offset binary, passed without MSB inversion
// - sixteen-bit word sampled on falling clock
// - link is clock, data, frame select
// - automatic or strobe-driven latch update
// - strobe low: load on sixteenth edge
// - standalone passes only sixteen edges
// - strobe high at frame start: strobe loads
// - four ignored bits, then data MSB first
// - chain mode: no gating, bits emerge out
`timescale 1ns/10ps
module serial_dac_input_logic
  import dac_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic host_transmit_frame_n,
  input wire logic latch_load_n,
  input wire logic latch_clear_n,
  input wire logic chain_enable,
  output logic serial_out,
  output logic [dac_pkg::DATA_BITS-1:0] dac_code,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import dac_pkg::*;

  pin_if pins ();

  logic [PIN_COUNT-1:0] pins_raw;
  logic frame_n;
  logic chain;
  logic clear_active;
  logic load_level_n;
  logic data_bit;

  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic [COUNT_BITS-1:0] count_q;
  logic [COUNT_BITS-1:0] count_d;
  logic [COUNT_BITS-1:0] count_base;
  logic auto_q;
  logic auto_d;
  logic [DATA_BITS-1:0] latch_q;
  logic [DATA_BITS-1:0] latch_d;
  logic sout_q;
  logic sout_d;
  logic [DATA_BITS-1:0] code_q;
  logic [DATA_BITS-1:0] code_d;
  logic pass_edge;
  logic auto_load;
  logic strobe_load;

  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [ADDR_BITS-1:0] wr_addr_q;
  logic [ADDR_BITS-1:0] wr_addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] status_word;
  logic bus_take;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // six pins: the three link pins plus load, clear and chain
  always_comb
  begin
    pins_raw = '0;
    pins_raw[PIN_SCLK] = shift_clock;
    pins_raw[PIN_FRAME] = host_transmit_frame_n;
    pins_raw[PIN_DATA] = serial_in;
    pins_raw[PIN_LOAD] = latch_load_n;
    pins_raw[PIN_CLEAR] = latch_clear_n;
    pins_raw[PIN_CHAIN] = chain_enable;
  end

  pin_sync u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pins_raw(pins_raw),
    .pins(pins)
  );

  assign frame_n = pins.level[PIN_FRAME];
  assign chain = pins.level[PIN_CHAIN];
  assign clear_active = ~pins.level[PIN_CLEAR];
  assign load_level_n = pins.level[PIN_LOAD];
  assign data_bit = pins.level[PIN_DATA];

  // ---------------------------------------------------------------
  // serial shift path and latch
  // ---------------------------------------------------------------
  always_comb
  begin
    // a new frame restarts the edge count
    count_base = pins.frame_fall ? COUNT_RESET : count_q;
    pass_edge = pins.sclk_fall & ~frame_n & (chain | (count_base < WORD_EDGES));
    shift_d = pass_edge ? {shift_q[WORD_BITS-2:0], data_bit} : shift_q;
    count_d = count_base;
    if (pass_edge && count_base < WORD_EDGES)
    begin
      count_d = count_base + 5'h01;
    end
    auto_d = pins.frame_fall ? ~load_level_n : auto_q;
    auto_load = pass_edge & auto_d & (count_base == LAST_EDGE_COUNT);
    strobe_load = pins.load_fall & ~auto_q & frame_n;
    latch_d = latch_q;
    if (auto_load || strobe_load)
    begin
      latch_d = shift_d[DATA_BITS-1:0];
    end
    if (clear_active)
    begin
      latch_d = LATCH_RESET;
    end
    sout_d = chain ? shift_d[WORD_BITS-1] : 1'b0;
    code_d = core_code(latch_d, ctrl_q[CTRL_FORMAT_BIT], ctrl_q[CTRL_BIPOLAR_BIT]);
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      shift_q <= SHIFT_RESET;
      count_q <= WORD_EDGES;
      auto_q <= 1'b0;
      latch_q <= LATCH_RESET;
      sout_q <= 1'b0;
      code_q <= CODE_RESET;
    end
    else
    begin
      shift_q <= shift_d;
      count_q <= count_d;
      auto_q <= auto_d;
      latch_q <= latch_d;
      sout_q <= sout_d;
      code_q <= code_d;
    end
  end

  assign serial_out = sout_q;
  assign dac_code = code_q;

  // ---------------------------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------------------------
  always_comb
  begin
    status_word = '0;
    status_word[STAT_AUTO_BIT] = auto_q;
    status_word[STAT_FRAME_BIT] = ~frame_n;
    status_word[STAT_CLEAR_BIT] = clear_active;
    status_word[STAT_CHAIN_BIT] = chain;
    status_word[STAT_COUNT_LSB +: COUNT_BITS] = count_q;
  end

  // address phase decode, write lands in the data phase
  always_comb
  begin
    bus_take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
    wr_pend_d = bus_take & hwrite;
    wr_addr_d = bus_take ? haddr[ADDR_BITS-1:0] : wr_addr_q;
    ctrl_d = ctrl_q;
    if (wr_pend_q && wr_addr_q == CTRL_ADDR)
    begin
      ctrl_d = hwdata[1:0];
    end
    rdata_d = RDATA_RESET;
    if (bus_take && !hwrite)
    begin
      unique case (haddr[ADDR_BITS-1:0])
        CTRL_ADDR: rdata_d = 32'(ctrl_q);
        STATUS_ADDR: rdata_d = status_word;
        LATCH_ADDR: rdata_d = {20'h0_0000, latch_q};
        CODE_ADDR: rdata_d = {20'h0_0000, code_q};
        SHIFT_ADDR: rdata_d = {16'h0000, shift_q};
        default: rdata_d = RDATA_RESET; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_q <= CTRL_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= CTRL_ADDR;
      rdata_q <= RDATA_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always OKAY

endmodule

// [testbench/dac_input_checker_asserts.sv]
// port checker for the serial converter front end
// assumes one clock domain and the top module's ports only
`timescale 1ns/10ps
module dac_input_checker
  import dac_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic host_transmit_frame_n,
  input wire logic latch_load_n,
  input wire logic latch_clear_n,
  input wire logic chain_enable,
  input wire logic serial_out,
  input wire logic [dac_pkg::DATA_BITS-1:0] dac_code,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  logic rd_req;
  logic quiet;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // read request decode and a link with nothing moving
  assign rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  assign quiet = host_transmit_frame_n && latch_load_n && latch_clear_n && !(hsel && hwrite);
  property p_clear;
    !latch_clear_n [*5] |=> (dac_code & 12'h7FF) == 12'h000;
  endproperty
  property p_chain_off;
    !chain_enable [*5] |=> !serial_out;
  endproperty
  property p_still;
    quiet [*8] |=> $stable(dac_code);
  endproperty
  property p_out_still;
    (host_transmit_frame_n && chain_enable) [*6] |=> $stable(serial_out);
  endproperty
  property p_code_read;
    rd_req && haddr == {24'h00_0000, CODE_ADDR} |=> hrdata[11:0] == $past(dac_code);
  endproperty
  property p_rdata_idle;
    !$past(rd_req || sys_rst) |-> hrdata == 32'h0000_0000;
  endproperty
  property p_ready;
    hreadyout;
  endproperty
  property p_okay;
    !hresp;
  endproperty
  a_clear: assert property (p_clear) else $error("latch not cleared");
  a_chain_off: assert property (p_chain_off) else $error("serial out active");
  a_still: assert property (p_still) else $error("code moved while idle");
  a_out_still: assert property (p_out_still) else $error("shift while frame high");
  a_code_read: assert property (p_code_read) else $error("code read wrong");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_ready: assert property (p_ready) else $error("wait state seen");
  a_okay: assert property (p_okay) else $error("error response");
  c_read: cover property (rd_req && haddr == {24'h00_0000, CODE_ADDR});
  c_clear: cover property (!latch_clear_n [*5]);
  c_chain: cover property (chain_enable && serial_out);
endmodule
bind serial_dac_input_logic dac_input_checker chk_i (.clock(clock), .sys_rst(sys_rst),
  .host_transmit_frame_n(host_transmit_frame_n), .latch_load_n(latch_load_n),
  .latch_clear_n(latch_clear_n), .chain_enable(chain_enable), .serial_out(serial_out),
  .dac_code(dac_code), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// [testbench/host_serial_port.sv]
// host serial port model: gated burst clock, data, framing
// assumes the bench calls send between frames
`timescale 1ns/10ps
module host_serial_port
(
  output logic shift_clock,
  output logic serial_in,
  output logic host_transmit_frame_n
);
  localparam real HALF = 62.5;
  logic host_frame_pulse;
  assign host_transmit_frame_n = ~host_frame_pulse;
  // idle: clock high, and still outside frames except when stray runs
  initial
  begin
    shift_clock = 1'b1;
    serial_in = 1'b0;
    host_frame_pulse = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    host_frame_pulse = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      serial_in = w[15 - (i % 16)];
      #(HALF);
      shift_clock = 1'b0;
      #(HALF);
      shift_clock = 1'b1;
    end
    #(HALF);
    host_frame_pulse = 1'b0;
    serial_in = ~serial_in; // released line shows the inverse
  endtask
  // stray clock edges with frame high
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      serial_in = ~serial_in;
      #(HALF);
      shift_clock = 1'b0;
      #(HALF);
      shift_clock = 1'b1;
    end
  endtask
endmodule

// [testbench/serial_dac_input_logic_test.sv]
// self-checking bench for the serial converter front end
// assumes the host port model and the bound port checker
`timescale 1ns/10ps
module serial_dac_input_logic_test;
  import dac_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic latch_load_n = 1'b0;
  logic latch_clear_n = 1'b0;
  logic chain_enable = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] rd;
  wire shift_clock, serial_in, host_transmit_frame_n, serial_out, hreadyout, hresp;
  wire [DATA_BITS-1:0] dac_code;
  wire [31:0] hrdata;
  int num_errors = 0;
  int n_tests = 0;
  always #2 clock = ~clock;
  host_serial_port host (.shift_clock(shift_clock), .serial_in(serial_in),
    .host_transmit_frame_n(host_transmit_frame_n));
  serial_dac_input_logic uut (.clock(clock), .sys_rst(sys_rst), .shift_clock(shift_clock),
    .serial_in(serial_in), .host_transmit_frame_n(host_transmit_frame_n),
    .latch_load_n(latch_load_n), .latch_clear_n(latch_clear_n), .chain_enable(chain_enable),
    .serial_out(serial_out), .dac_code(dac_code), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic code_is(input logic [11:0] e);
    chk("dac_code", {20'h0_0000, dac_code}, {20'h0_0000, e});
  endtask
  // one single-word transfer, read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic word(input logic [15:0] w, input int n);
    host.send(w, n);
    repeat (8) @(posedge clock);
  endtask
  task automatic pulse_load();
    @(posedge clock);
    latch_load_n <= 1'b0;
    repeat (8) @(posedge clock);
    latch_load_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power();
    code_is(12'h000);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    latch_clear_n <= 1'b1;
  endtask
  task automatic t_auto();
    word(16'hFABC, 16);
    code_is(12'hABC);
    bus(1'b0, LATCH_ADDR, 32'h0000_0000);
    chk("latch", rd, 32'h0000_0ABC);
    word(16'h3C5A, 20);
    code_is(12'hC5A);
    bus(1'b0, SHIFT_ADDR, 32'h0000_0000);
    chk("shift", rd, 32'h0000_3C5A);
    bus(1'b0, STATUS_ADDR, 32'h0000_0000);
    chk("status", rd, 32'h0000_0101);
  endtask
  task automatic t_strobe();
    latch_load_n <= 1'b1;
    repeat (4) @(posedge clock);
    word(16'h0123, 16);
    code_is(12'hC5A);
    bus(1'b0, STATUS_ADDR, 32'h0000_0000);
    chk("status", rd, 32'h0000_0100);
    pulse_load();
    code_is(12'h123);
  endtask
  task automatic t_chain();
    chain_enable <= 1'b1;
    word(16'h3C5A, 20);
    chk("serial_out", 32'(serial_out), 32'h0000_0001);
    host.stray(8);
    repeat (8) @(posedge clock);
    chk("serial_out", 32'(serial_out), 32'h0000_0001);
    bus(1'b0, SHIFT_ADDR, 32'h0000_0000);
    chk("shift", rd, 32'h0000_C5A3);
    pulse_load();
    code_is(12'h5A3);
    chain_enable <= 1'b0;
  endtask
  task automatic t_format();
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, CTRL_ADDR, 32'(c));
      bus(1'b0, CTRL_ADDR, 32'h0000_0000);
      chk("ctrl", rd, 32'(c));
      bus(1'b0, CODE_ADDR, 32'h0000_0000);
      chk("code", rd, (c == 3) ? 32'h0000_0DA3 : 32'h0000_05A3);
    end
  endtask
  task automatic t_clear();
    latch_clear_n <= 1'b0;
    latch_load_n <= 1'b0;
    word(16'hFABC, 16);
    code_is(12'h800);
    latch_clear_n <= 1'b1;
    bus(1'b1, CTRL_ADDR, 32'h0000_0000);
    repeat (4) @(posedge clock);
    code_is(12'h000);
  endtask
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_power();
    t_auto();
    t_strobe();
    t_chain();
    t_format();
    t_clear();
    print_verdict();
  end
  initial
  begin
    #200000;
    num_errors++;
    print_verdict();
  end
endmodule
